// ---- src/usio_params.svh ----
// constants for the user signal input/output bank: timing, register offsets, resets
// assumes a 50 MHz core clock and a 12-bit APB byte address
`ifndef USIO_PARAMS_SVH
`define USIO_PARAMS_SVH

`define USIO_CLK_MHZ 50
`define USIO_PULSE_US 5000
`define USIO_PULSE_CYCLES (`USIO_PULSE_US * `USIO_CLK_MHZ)
`define USIO_MS_US 1000
`define USIO_MS_CYCLES (`USIO_MS_US * `USIO_CLK_MHZ)

`define USIO_OFS_IN_STATE 12'h000
`define USIO_OFS_IN_SET 12'h004
`define USIO_OFS_IN_CLR 12'h008
`define USIO_OFS_IN_MODE 12'h00C
`define USIO_OFS_OUT_STATE 12'h010
`define USIO_OFS_OUT_ON_SEL 12'h014
`define USIO_OFS_OUT_OFF_SEL 12'h018
`define USIO_OFS_IN_ON_SEL 12'h01C
`define USIO_OFS_IN_OFF_SEL 12'h020
`define USIO_OFS_STRETCH_EN 12'h024
`define USIO_OFS_STRETCH_MS 12'h028
`define USIO_OFS_TIME 12'h02C
`define USIO_OFS_IRQ_STAT 12'h030
`define USIO_OFS_IRQ_MASK 12'h034

`define USIO_RST_SEL 32'hFFFFFFFF
`define USIO_RST_MODE 32'h00000000
`define USIO_RST_STRETCH_EN 32'h00000000
`define USIO_RST_STRETCH_MS 16'h0000
`define USIO_RST_IRQ_MASK 3'h0

`define USIO_IRQ_OUT_EVT 0
`define USIO_IRQ_IN_EVT 1
`define USIO_IRQ_LOST 2

`endif

// ---- src/usio_pkg.sv ----
// types shared by the user signal input/output bank and its surroundings
// assumes nothing beyond a SystemVerilog tool
package usio_pkg;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } usio_apb_req_t;

    typedef struct packed {
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } usio_apb_rsp_t;

    // local virtual switch command: value 1 sets, value 0 clears
    typedef struct packed {
        logic valid;
        logic [4:0] index;
        logic value;
    } usio_cmd_t;

    typedef enum logic {
        usio_output_event_group,
        usio_input_event_group
    } usio_grp_t;

    typedef struct packed {
        usio_grp_t group;
        logic [5:0] index;
        logic is_on;
        logic [31:0] stamp;
    } usio_evt_t;

endpackage : usio_pkg

// ---- src/usio_evt_pick.sv ----
// picks the lowest-numbered pending event slot
// assumes pend comes from flops on the same clock; purely combinational
`timescale 1ns/10ps
module usio_evt_pick #(
    parameter int N = 64
) (
    input wire logic [N-1:0] pend,
    output logic found,
    output logic [$clog2(N)-1:0] index
);
    import usio_pkg::*;

    if (N < 2) begin : g_bad_n
        $error("usio_evt_pick needs at least two slots");
    end

    always_comb begin
        found = 1'b0;
        index = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (pend[i]) begin
                found = 1'b1;
                index = ($clog2(N))'(i);
            end
        end
    end

endmodule : usio_evt_pick

// ---- src/usio_off_delay.sv ----
// off-delay stretcher: an enabled bit stays high delay_ms ticks after its input drops
// assumes ms_tick is a one-cycle pulse every millisecond on the same clock
`timescale 1ns/10ps
module usio_off_delay #(
    parameter int N = 32,
    parameter int DW = 16
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic ms_tick,
    input wire logic [N-1:0] enable,
    input wire logic [DW-1:0] delay_ms,
    input wire logic [N-1:0] din,
    output logic [N-1:0] dout
);
    import usio_pkg::*;

    if (N < 1 || DW < 1) begin : g_bad_size
        $error("usio_off_delay needs N and DW of at least one");
    end

    typedef struct packed {
        logic [N-1:0] out;
        logic [N-1:0][DW-1:0] cnt;
    } usio_dly_st_t;

    usio_dly_st_t st;
    usio_dly_st_t next_st;

    // the first partial millisecond counts, so the hold is delay-1 to delay ms
    always_comb begin
        next_st = st;
        for (int i = 0; i < N; i++) begin
            if (din[i]) begin
                next_st.out[i] = 1'b1;
                next_st.cnt[i] = delay_ms;
            end else if (!enable[i] || st.cnt[i] == '0) begin
                next_st.out[i] = 1'b0;
                next_st.cnt[i] = '0;
            end else begin
                next_st.out[i] = 1'b1;
                if (ms_tick) begin
                    next_st.cnt[i] = st.cnt[i] - 1'b1;
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign dout = st.out;

endmodule : usio_off_delay

// ---- src/usio_core.sv ----
// user signal input/output bank: 32 command-driven inputs, 32 logic-driven outputs,
// timestamped ON/OFF events and an APB register file
// assumes APB master and user logic on core_clk; rstn is the device restart
`timescale 1ns/10ps
`include "usio_params.svh"
module usio_core #(
    parameter int unsigned PULSE_CYCLES = `USIO_PULSE_CYCLES,
    parameter int unsigned MS_CYCLES = `USIO_MS_CYCLES,
    parameter int STRETCH_W = 16
) (
    input wire logic core_clk,
    input wire logic rstn,
    input usio_pkg::usio_apb_req_t apb_req,
    output usio_pkg::usio_apb_rsp_t apb_rsp,
    input usio_pkg::usio_cmd_t panel_cmd,
    input wire logic [31:0] user_logic_result,
    output logic [31:0] user_output_signal,
    output logic [31:0] user_input_signal,
    output logic evt_valid,
    input wire logic evt_ready,
    output usio_pkg::usio_evt_t evt,
    output logic irq
);
    import usio_pkg::*;

    localparam int NSIG = 32;
    localparam int NSLOT = 2 * NSIG;
    localparam int CW = $clog2(PULSE_CYCLES + 1);
    localparam int MW = $clog2(MS_CYCLES + 1);

    if (PULSE_CYCLES < 2 || MS_CYCLES < 2) begin : g_bad_time
        $error("usio_core needs pulse and millisecond counts of at least two");
    end
    if (STRETCH_W < 1 || STRETCH_W > 32) begin : g_bad_stretch
        $error("usio_core stretch width must be 1 to 32");
    end

    typedef struct packed {
        logic [NSIG-1:0] in_state;
        logic [NSIG-1:0] in_mode;
        logic [NSIG-1:0][CW-1:0] pulse_cnt;
        logic [NSIG-1:0] out_prev;
        logic [NSIG-1:0] out_on_sel;
        logic [NSIG-1:0] out_off_sel;
        logic [NSIG-1:0] in_on_sel;
        logic [NSIG-1:0] in_off_sel;
        logic [NSIG-1:0] stretch_en;
        logic [STRETCH_W-1:0] stretch_ms;
        logic [31:0] time_now;
        logic [MW-1:0] ms_cnt;
        logic ms_tick;
        logic [NSLOT-1:0] pend;
        logic [NSLOT-1:0] pend_on;
        logic [NSLOT-1:0][31:0] stamp;
        logic evt_valid;
        usio_evt_t evt;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic [31:0] rdata;
        logic rerr;
    } usio_core_st_t;

    usio_core_st_t st;
    usio_core_st_t next_st;

    logic [NSIG-1:0] out_sig;
    logic pick_found;
    logic [$clog2(NSLOT)-1:0] pick_idx;

    // stretched outputs are what the rest of the device and the events see
    usio_off_delay #(
        .N(NSIG),
        .DW(STRETCH_W)
    ) u_off_delay (
        .core_clk(core_clk),
        .rstn(rstn),
        .ms_tick(st.ms_tick),
        .enable(st.stretch_en),
        .delay_ms(st.stretch_ms),
        .din(user_logic_result),
        .dout(out_sig)
    );

    usio_evt_pick #(
        .N(NSLOT)
    ) u_evt_pick (
        .pend(st.pend),
        .found(pick_found),
        .index(pick_idx)
    );

    logic apb_setup;
    logic apb_access;
    logic apb_wr;
    logic [NSIG-1:0] set_m;
    logic [NSIG-1:0] clr_m;
    logic [NSLOT-1:0] chg;
    logic [NSLOT-1:0] lvl;
    logic [NSLOT-1:0] keep;
    logic [NSLOT-1:0] on_sel;
    logic [NSLOT-1:0] off_sel;
    logic lost;
    logic [2:0] irq_set;
    logic [2:0] irq_clr;

    assign apb_setup = apb_req.psel && !apb_req.penable;
    assign apb_access = apb_req.psel && apb_req.penable;
    assign apb_wr = apb_access && apb_req.pwrite;

    always_comb begin
        next_st = st;
        set_m = '0;
        clr_m = '0;
        lost = 1'b0;
        irq_clr = '0;

        next_st.time_now = st.time_now + 32'h00000001;
        if (st.ms_cnt == MW'(MS_CYCLES - 1)) begin
            next_st.ms_cnt = '0;
            next_st.ms_tick = 1'b1;
        end else begin
            next_st.ms_cnt = st.ms_cnt + 1'b1;
            next_st.ms_tick = 1'b0;
        end

        // panel and link commands in the same cycle merge; set beats clear on one bit
        if (panel_cmd.valid) begin
            if (panel_cmd.value) begin
                set_m[panel_cmd.index] = 1'b1;
            end else begin
                clr_m[panel_cmd.index] = 1'b1;
            end
        end
        if (apb_wr && apb_req.paddr == `USIO_OFS_IN_SET) begin
            set_m = set_m | apb_req.pwdata;
        end
        if (apb_wr && apb_req.paddr == `USIO_OFS_IN_CLR) begin
            clr_m = clr_m | apb_req.pwdata;
        end

        for (int i = 0; i < NSIG; i++) begin
            if (set_m[i]) begin
                next_st.in_state[i] = 1'b1;
                // a repeated set reloads the count, restarting the pulse
                next_st.pulse_cnt[i] = st.in_mode[i] ? CW'(PULSE_CYCLES - 1) : '0;
            end else if (clr_m[i]) begin
                next_st.in_state[i] = 1'b0;
                next_st.pulse_cnt[i] = '0;
            end else if (st.in_mode[i] && st.in_state[i]) begin
                if (st.pulse_cnt[i] == '0) begin
                    next_st.in_state[i] = 1'b0;
                end else begin
                    next_st.pulse_cnt[i] = st.pulse_cnt[i] - 1'b1;
                end
            end
        end

        // slots 0..31 are outputs, 32..63 are inputs
        next_st.out_prev = out_sig;
        chg = {next_st.in_state ^ st.in_state, out_sig ^ st.out_prev};
        lvl = {next_st.in_state, out_sig};
        on_sel = {st.in_on_sel, st.out_on_sel};
        off_sel = {st.in_off_sel, st.out_off_sel};
        keep = chg & ((lvl & on_sel) | (~lvl & off_sel));

        if (!st.evt_valid || evt_ready) begin
            next_st.evt_valid = pick_found;
            if (pick_found) begin
                next_st.pend[pick_idx] = 1'b0;
                next_st.evt.group = pick_idx[5] ? usio_input_event_group
                                                : usio_output_event_group;
                next_st.evt.index = {1'b0, pick_idx[4:0]} + 6'h01;
                next_st.evt.is_on = st.pend_on[pick_idx];
                next_st.evt.stamp = st.stamp[pick_idx];
            end
        end

        // one slot per signal, shared by both edges; a second change before drain overwrites
        for (int j = 0; j < NSLOT; j++) begin
            if (keep[j]) begin
                if (next_st.pend[j]) begin
                    lost = 1'b1;
                end
                next_st.pend[j] = 1'b1;
                next_st.pend_on[j] = lvl[j];
                next_st.stamp[j] = st.time_now;
            end
        end

        irq_set = '0;
        irq_set[`USIO_IRQ_OUT_EVT] = |keep[NSIG-1:0];
        irq_set[`USIO_IRQ_IN_EVT] = |keep[NSLOT-1:NSIG];
        irq_set[`USIO_IRQ_LOST] = lost;

        if (apb_wr) begin
            unique case (apb_req.paddr)
                `USIO_OFS_IN_MODE: next_st.in_mode = apb_req.pwdata;
                `USIO_OFS_OUT_ON_SEL: next_st.out_on_sel = apb_req.pwdata;
                `USIO_OFS_OUT_OFF_SEL: next_st.out_off_sel = apb_req.pwdata;
                `USIO_OFS_IN_ON_SEL: next_st.in_on_sel = apb_req.pwdata;
                `USIO_OFS_IN_OFF_SEL: next_st.in_off_sel = apb_req.pwdata;
                `USIO_OFS_STRETCH_EN: next_st.stretch_en = apb_req.pwdata;
                `USIO_OFS_STRETCH_MS: next_st.stretch_ms = apb_req.pwdata[STRETCH_W-1:0];
                `USIO_OFS_IRQ_STAT: irq_clr = apb_req.pwdata[2:0];
                `USIO_OFS_IRQ_MASK: next_st.irq_mask = apb_req.pwdata[2:0];
                default: begin
                end
            endcase
        end
        // an event in the clearing cycle survives
        next_st.irq_stat = (st.irq_stat & ~irq_clr) | irq_set;

        // read data and decode are captured in the setup cycle, answered in access
        if (apb_setup) begin
            next_st.rerr = 1'b0;
            unique case (apb_req.paddr)
                `USIO_OFS_IN_STATE: next_st.rdata = st.in_state;
                `USIO_OFS_IN_SET: next_st.rdata = '0;
                `USIO_OFS_IN_CLR: next_st.rdata = '0;
                `USIO_OFS_IN_MODE: next_st.rdata = st.in_mode;
                `USIO_OFS_OUT_STATE: next_st.rdata = out_sig;
                `USIO_OFS_OUT_ON_SEL: next_st.rdata = st.out_on_sel;
                `USIO_OFS_OUT_OFF_SEL: next_st.rdata = st.out_off_sel;
                `USIO_OFS_IN_ON_SEL: next_st.rdata = st.in_on_sel;
                `USIO_OFS_IN_OFF_SEL: next_st.rdata = st.in_off_sel;
                `USIO_OFS_STRETCH_EN: next_st.rdata = st.stretch_en;
                `USIO_OFS_STRETCH_MS: next_st.rdata = 32'(st.stretch_ms);
                `USIO_OFS_TIME: next_st.rdata = st.time_now;
                `USIO_OFS_IRQ_STAT: next_st.rdata = {29'h0, st.irq_stat};
                `USIO_OFS_IRQ_MASK: next_st.rdata = {29'h0, st.irq_mask};
                default: begin
                    next_st.rdata = '0;
                    next_st.rerr = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            st <= '0;
            st.in_mode <= `USIO_RST_MODE;
            st.out_on_sel <= `USIO_RST_SEL;
            st.out_off_sel <= `USIO_RST_SEL;
            st.in_on_sel <= `USIO_RST_SEL;
            st.in_off_sel <= `USIO_RST_SEL;
            st.stretch_en <= `USIO_RST_STRETCH_EN;
            st.stretch_ms <= STRETCH_W'(`USIO_RST_STRETCH_MS);
            st.irq_mask <= `USIO_RST_IRQ_MASK;
        end else begin
            st <= next_st;
        end
    end

    // zero-wait slave: access phase always completes in its first cycle
    assign apb_rsp.pready = apb_access;
    assign apb_rsp.prdata = st.rdata;
    assign apb_rsp.pslverr = apb_access && st.rerr;

    assign user_output_signal = out_sig;
    assign user_input_signal = st.in_state;
    assign evt_valid = st.evt_valid;
    assign evt = st.evt;
    assign irq = |(st.irq_stat & st.irq_mask);

endmodule : usio_core

// ---- testbench/usio_core_checker.sv ----
// concurrent checks on the ports of the user signal bank
// assumes one clock, core_clk, and synchronous active-low rstn
`timescale 1ns/10ps
module usio_core_checker (
    input wire logic core_clk,
    input wire logic rstn,
    input usio_pkg::usio_apb_req_t apb_req,
    input usio_pkg::usio_apb_rsp_t apb_rsp,
    input usio_pkg::usio_cmd_t panel_cmd,
    input wire logic [31:0] user_logic_result,
    input wire logic [31:0] user_output_signal,
    input wire logic [31:0] user_input_signal,
    input wire logic evt_valid,
    input wire logic evt_ready,
    input usio_pkg::usio_evt_t evt,
    input wire logic irq
);
    import usio_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // apb writes in the same cycle could merge with the command, so they are excluded
    sequence s_cmd_set;
        panel_cmd.valid && panel_cmd.value && !apb_req.psel;
    endsequence
    sequence s_cmd_clr;
        panel_cmd.valid && !panel_cmd.value && !apb_req.psel;
    endsequence
    property p_pready;
        apb_req.psel && apb_req.penable |-> apb_rsp.pready;
    endproperty
    property p_err_idle;
        !(apb_req.psel && apb_req.penable) |-> !apb_rsp.pslverr;
    endproperty
    property p_reset;
        disable iff (1'b0) !rstn |=> user_input_signal == 32'h0 && !evt_valid && !irq;
    endproperty
    property p_set;
        s_cmd_set |=> user_input_signal[$past(panel_cmd.index)];
    endproperty
    property p_clr;
        s_cmd_clr |=> !user_input_signal[$past(panel_cmd.index)];
    endproperty
    property p_out;
        1'b1 |=> (user_output_signal & $past(user_logic_result)) == $past(user_logic_result);
    endproperty
    property p_evt_hold;
        evt_valid && !evt_ready |=> evt_valid && $stable(evt);
    endproperty
    property p_evt_idx;
        evt_valid |-> evt.index >= 6'h01 && evt.index <= 6'h20;
    endproperty
    a_pready: assert property (p_pready) else $error("pready missing in access");
    a_err_idle: assert property (p_err_idle) else $error("pslverr outside access");
    a_reset: assert property (p_reset) else $error("state not cleared by restart");
    a_set: assert property (p_set) else $error("set command not applied");
    a_clr: assert property (p_clr) else $error("clear command not applied");
    a_out: assert property (p_out) else $error("output missed user logic result");
    a_evt_hold: assert property (p_evt_hold) else $error("event changed while stalled");
    a_evt_idx: assert property (p_evt_idx) else $error("event index out of range");
endmodule : usio_core_checker

bind usio_core usio_core_checker u_chk (
    .core_clk(core_clk),
    .rstn(rstn),
    .apb_req(apb_req),
    .apb_rsp(apb_rsp),
    .panel_cmd(panel_cmd),
    .user_logic_result(user_logic_result),
    .user_output_signal(user_output_signal),
    .user_input_signal(user_input_signal),
    .evt_valid(evt_valid),
    .evt_ready(evt_ready),
    .evt(evt),
    .irq(irq)
);

// ---- testbench/usio_evt_sink.sv ----
// event buffer at the far side: takes events at once or stalls three cycles in four
// assumes evt_valid is registered on core_clk
`timescale 1ns/10ps
module usio_evt_sink (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic slow,
    input wire logic evt_valid,
    output logic evt_ready
);
    logic [1:0] div;
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            div <= 2'h0;
        end else begin
            div <= div + 2'h1;
        end
    end
    // stalling lets several slots back up so the pick order shows
    assign evt_ready = slow ? (div == 2'h3) : 1'b1;
endmodule : usio_evt_sink

// ---- testbench/usio_core_tb_top.sv ----
// self-checking bench for the user signal bank: apb master, panel commands, user logic
// assumes short pulse and millisecond counts set through parameters
`timescale 1ns/10ps
module usio_core_tb_top;
    import usio_pkg::*;
    localparam int PC = 20;
    localparam int MC = 10;
    logic core_clk, rstn, slow, ev_v, ev_r, irq;
    usio_apb_req_t req;
    usio_apb_rsp_t rsp;
    usio_cmd_t cmd;
    usio_evt_t ev;
    logic [31:0] res, uo, ui, r;
    int n_errors, checked, n;
    logic [32:0] exp_rd[$];
    logic [7:0] exp_ev[$];

    usio_core #(.PULSE_CYCLES(PC), .MS_CYCLES(MC)) dut (.core_clk(core_clk), .rstn(rstn),
        .apb_req(req), .apb_rsp(rsp), .panel_cmd(cmd), .user_logic_result(res),
        .user_output_signal(uo), .user_input_signal(ui), .evt_valid(ev_v),
        .evt_ready(ev_r), .evt(ev), .irq(irq));
    usio_evt_sink sink (.core_clk(core_clk), .rstn(rstn), .slow(slow), .evt_valid(ev_v),
        .evt_ready(ev_r));

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task check(input logic [32:0] seen, input logic [32:0] expv);
        checked++;
        if (seen !== expv) begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, expv);
        end
    endtask : check

    task test_done;
        $display("errors=%0d checks=%0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : test_done

    function automatic logic [7:0] k(input logic g, input int i, input logic on);
        return {g, i[5:0], on};
    endfunction : k

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
        exp_rd.push_back(e);
        @(posedge core_clk);
        req <= '{1'b1, 1'b0, wr, a, d};
        @(posedge core_clk);
        req.penable <= 1'b1;
        do @(posedge core_clk); while (rsp.pready !== 1'b1);
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb

    task cmd_go(input logic [4:0] i, input logic v);
        @(posedge core_clk);
        cmd <= '{1'b1, i, v};
        @(posedge core_clk);
        cmd.valid <= 1'b0;
        #1;
    endtask : cmd_go

    task drain;
        for (int j = 0; j < 2000 && exp_ev.size() != 0; j++) @(posedge core_clk);
        repeat (6) @(posedge core_clk);
    endtask : drain

    // results are compared in the order they appear at the ports
    always @(posedge core_clk) begin
        if (req.psel && req.penable && rsp.pready) begin
            check({rsp.pslverr, req.pwrite ? 32'h0 : rsp.prdata}, exp_rd.pop_front());
        end
        if (ev_v && ev_r) begin
            check({25'h0, ev.group, ev.index, ev.is_on}, exp_ev.pop_front());
        end
    end

    initial begin
        repeat (30000) @(posedge core_clk);
        n_errors++;
        test_done();
    end

    initial begin
        void'($urandom(32'hCDB00008));
        n_errors = 0;
        checked = 0;
        rstn = 1'b0;
        slow = 1'b0;
        req = '0;
        cmd = '0;
        res = '0;
        repeat (10) @(posedge core_clk);
        rstn <= 1'b1;
        apb(0, 12'h014, 32'h0, {1'b0, 32'hFFFFFFFF});
        apb(0, 12'h00C, 32'h0, 33'h0);
        apb(0, 12'h000, 32'h0, 33'h0);
        apb(0, 12'h040, 32'h0, {1'b1, 32'h0});
        apb(1, 12'h034, 32'h7, 33'h0);
        slow <= 1'b1;
        r = $urandom();
        r[0] = 1'b1;
        for (int i = 0; i < 32; i++) if (r[i]) exp_ev.push_back(k(0, i + 1, 1));
        res <= r;
        drain();
        apb(0, 12'h010, 32'h0, {1'b0, r});
        apb(0, 12'h030, 32'h0, 33'h1);
        #1 check(irq, 1);
        apb(1, 12'h030, 32'h1, 33'h0);
        #1 check(irq, 0);
        // off events deselected, so nothing may reach the buffer
        apb(1, 12'h018, 32'h0, 33'h0);
        res <= 32'h0;
        drain();
        check(irq, 0);
        apb(1, 12'h024, 32'h1, 33'h0);
        apb(1, 12'h028, 32'h2, 33'h0);
        exp_ev.push_back(k(0, 1, 1));
        res <= 32'h1;
        repeat (3) @(posedge core_clk);
        res <= 32'h0;
        @(posedge core_clk);
        #1 n = 0;
        while (uo[0] === 1'b1 && n < 100) begin
            @(posedge core_clk);
            #1 n++;
        end
        check(n > MC - 2 && n < 2 * MC + 3, 1);
        drain();
        slow <= 1'b0;
        exp_ev.push_back(k(1, 6, 1));
        cmd_go(5'h05, 1'b1);
        repeat (3 * PC) @(posedge core_clk);
        #1 check(ui[5], 1);
        exp_ev.push_back(k(1, 6, 0));
        cmd_go(5'h05, 1'b0);
        check(ui[5], 0);
        apb(1, 12'h00C, 32'h4, 33'h0);
        exp_ev.push_back(k(1, 3, 1));
        exp_ev.push_back(k(1, 3, 0));
        cmd_go(5'h02, 1'b1);
        repeat (5) @(posedge core_clk);
        cmd_go(5'h02, 1'b1);
        n = 0;
        while (ui[2] === 1'b1 && n < 100) begin
            @(posedge core_clk);
            #1 n++;
        end
        check(n, PC);
        drain();
        exp_ev.push_back(k(1, 3, 1));
        exp_ev.push_back(k(1, 3, 0));
        cmd_go(5'h02, 1'b1);
        repeat (4) @(posedge core_clk);
        cmd_go(5'h02, 1'b0);
        check(ui[2], 0);
        drain();
        apb(1, 12'h00C, 32'h0, 33'h0);
        exp_ev.push_back(k(1, 32, 1));
        apb(1, 12'h004, 32'h80000000, 33'h0);
        apb(0, 12'h000, 32'h0, {1'b0, 32'h80000000});
        exp_ev.push_back(k(1, 32, 0));
        apb(1, 12'h008, 32'h80000000, 33'h0);
        drain();
        apb(1, 12'h034, 32'h0, 33'h0);
        apb(0, 12'h030, 32'h0, 33'h3);
        #1 check(irq, 0);
        apb(1, 12'h034, 32'h7, 33'h0);
        #1 check(irq, 1);
        exp_ev.push_back(k(1, 8, 1));
        cmd_go(5'h07, 1'b1);
        drain();
        rstn <= 1'b0;
        repeat (3) @(posedge core_clk);
        rstn <= 1'b1;
        #1 check({irq, ui}, 33'h0);
        repeat (4) @(posedge core_clk);
        test_done();
    end
endmodule : usio_core_tb_top
